// >>> hw/sehp_pkg.sv
package sehp_pkg;

  localparam int BYTE_W = 8;
  localparam int MEM_DEPTH = 8192;
  localparam int FIFO_DEPTH = 2;
  localparam int ADDR_BYTE_W = 16;

  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;

  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  localparam logic CS_N_RST = 1'b1;
  localparam logic HOLD_N_RST = 1'b1;
  localparam logic TOG_RST = 1'b0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  localparam longint CLK_FREQ_HZ = 250000000;
  localparam longint WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES = int'((WRITE_TIME_MS * CLK_FREQ_HZ) / 1000);

  typedef enum logic [6:0] {
    ST_CMD     = 7'h01,
    ST_ADDR_HI = 7'h02,
    ST_ADDR_LO = 7'h04,
    ST_FETCH   = 7'h08,
    ST_READ    = 7'h10,
    ST_WDATA   = 7'h20,
    ST_DROP    = 7'h40
  } sehp_state_e;

endpackage : sehp_pkg

// >>> hw/sehp_byte_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sehp_byte_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface : sehp_byte_if

`default_nettype wire

// >>> hw/sehp_fifo2.sv
`timescale 1ns/1ps
`default_nettype none

module sehp_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  sehp_byte_if.rx i_wr,
  sehp_byte_if.tx o_rd
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] wr_d;
  logic [PW-1:0] rd_q;
  logic [PW-1:0] rd_d;
  logic [PW:0] cnt_q;
  logic [PW:0] cnt_d;
  logic push;
  logic pop;

  assign i_wr.ready = (cnt_q != (PW+1)'(DEPTH));
  assign o_rd.valid = (cnt_q != '0);
  assign o_rd.data = mem_q[rd_q];
  assign push = i_wr.valid & i_wr.ready;
  assign pop = o_rd.valid & o_rd.ready;

  always_comb
  begin
    wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop)
    begin
      cnt_d = (PW+1)'(cnt_q + 1'b1);
    end
    else if (pop && !push)
    begin
      cnt_d = (PW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= i_wr.data;
    end
  end
endmodule : sehp_fifo2

`default_nettype wire

// >>> hw/sehp_link.sv
`timescale 1ns/1ps
`default_nettype none

module sehp_link (
  input wire logic i_sck,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_hold_n,
  input wire logic i_si,
  input wire logic [7:0] i_tx_even,
  input wire logic [7:0] i_tx_odd,
  output logic [7:0] o_rx_byte,
  output logic o_rx_tog,
  output logic o_so
);
  logic rst_link;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [6:0] sh_q;
  logic [6:0] sh_d;
  logic [7:0] rx_q;
  logic [7:0] rx_d;
  logic tog_q;
  logic tog_d;
  logic par_q;
  logic par_d;
  logic [7:0] txsh_q;
  logic [7:0] txsh_d;
  logic so_q;
  logic so_d;
  logic [7:0] load;

  // Deselect clears the bit counter, shift registers, parity and output bit (not the handed-over byte or its toggle), so each frame starts at bit zero.
  assign rst_link = i_rst | i_cs_n;
  assign o_rx_byte = rx_q;
  assign o_rx_tog = tog_q;
  assign o_so = so_q;

  // The pause level is only changed while the clock is low, so it is stable at both edges.
  always_comb
  begin
    bit_d = bit_q;
    sh_d = sh_q;
    rx_d = rx_q;
    tog_d = tog_q;
    par_d = par_q;
    if (i_hold_n && !i_cs_n)
    begin
      sh_d = {sh_q[5:0], i_si};
      bit_d = 3'(bit_q + 1'b1);
      if (bit_q == sehp_pkg::BIT_LAST)
      begin
        rx_d = {sh_q, i_si};
        tog_d = ~tog_q;
        par_d = ~par_q;
      end
    end
  end

  always_ff @(posedge i_sck or posedge rst_link)
  begin
    if (rst_link)
    begin
      bit_q <= sehp_pkg::BIT_FIRST;
      sh_q <= '0;
      par_q <= 1'b0;
    end
    else
    begin
      bit_q <= bit_d;
      sh_q <= sh_d;
      par_q <= par_d;
    end
  end

  // The handed-over byte and its toggle survive deselect, so a frame end never fakes a new byte.
  always_ff @(posedge i_sck or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_q <= sehp_pkg::BYTE_RST;
      tog_q <= sehp_pkg::TOG_RST;
    end
    else
    begin
      rx_q <= rx_d;
      tog_q <= tog_d;
    end
  end

  // Byte k is loaded from the buffer register of parity k at the falling edge that ends byte k-1.
  always_comb
  begin
    load = par_q ? i_tx_odd : i_tx_even;
    txsh_d = txsh_q;
    so_d = so_q;
    if (i_hold_n)
    begin
      if (bit_q == sehp_pkg::BIT_FIRST)
      begin
        so_d = load[7];
        txsh_d = {load[6:0], 1'b0};
      end
      else
      begin
        so_d = txsh_q[7];
        txsh_d = {txsh_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(negedge i_sck or posedge rst_link)
  begin
    if (rst_link)
    begin
      txsh_q <= sehp_pkg::BYTE_RST;
      so_q <= 1'b0;
    end
    else
    begin
      txsh_q <= txsh_d;
      so_q <= so_d;
    end
  end
endmodule : sehp_link

`default_nettype wire

// >>> hw/sehp_eeprom_port.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Input bits sampled on serial clock rise.
// - Output bit changes only after clock fall, or clears on deselect.
// - Pause freezes sequence, keeps partial progress.
// - While paused input ignored, output floats.
// - Clock toggling while paused shifts nothing.
// - Array of bytes, depth per variant.
// - Deselected: no input taken, output floats.
module sehp_eeprom_port #(
  parameter int DEPTH = sehp_pkg::MEM_DEPTH,
  parameter int WRITE_CYCLES = sehp_pkg::WRITE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_hold_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  output logic o_busy
);
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Address helpers.

  function automatic logic [ADDR_W-1:0] addr_dec(input logic [15:0] a);
    addr_dec = a[ADDR_W-1:0];
  endfunction : addr_dec

  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    addr_inc = ADDR_W'(a + 1'b1);
  endfunction : addr_inc

  ////////////////////////////////////////////////////////////////////////////////
  // Link side and crossing.

  logic [7:0] rx_byte;
  logic rx_tog;
  logic [7:0] tx_even_q;
  logic [7:0] tx_even_d;
  logic [7:0] tx_odd_q;
  logic [7:0] tx_odd_d;

  sehp_link u_link (
    .i_sck(i_sck),
    .i_rst(i_rst),
    .i_cs_n(i_cs_n),
    .i_hold_n(i_hold_n),
    .i_si(i_si),
    .i_tx_even(tx_even_q),
    .i_tx_odd(tx_odd_q),
    .o_rx_byte(rx_byte),
    .o_rx_tog(rx_tog),
    .o_so(o_so)
  );

  logic cs_s1_q;
  logic cs_s2_q;
  logic hold_s1_q;
  logic hold_s2_q;
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic rx_pulse;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cs_s1_q <= sehp_pkg::CS_N_RST;
      cs_s2_q <= sehp_pkg::CS_N_RST;
      hold_s1_q <= sehp_pkg::HOLD_N_RST;
      hold_s2_q <= sehp_pkg::HOLD_N_RST;
      tog_s1_q <= sehp_pkg::TOG_RST;
      tog_s2_q <= sehp_pkg::TOG_RST;
      tog_s3_q <= sehp_pkg::TOG_RST;
    end
    else
    begin
      cs_s1_q <= i_cs_n;
      cs_s2_q <= cs_s1_q;
      hold_s1_q <= i_hold_n;
      hold_s2_q <= hold_s1_q;
      tog_s1_q <= rx_tog;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // The received byte stays put for a whole byte time after its toggle flips.
  assign rx_pulse = tog_s2_q ^ tog_s3_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pending byte and two-entry buffer.

  sehp_byte_if #(.WIDTH(sehp_pkg::BYTE_W)) fill_if ();
  sehp_byte_if #(.WIDTH(sehp_pkg::BYTE_W)) drain_if ();

  logic pend_q;
  logic pend_d;
  logic [7:0] pend_byte_q;
  logic [7:0] pend_byte_d;

  assign fill_if.valid = pend_q;
  assign fill_if.data = pend_byte_q;

  always_comb
  begin
    pend_d = pend_q;
    pend_byte_d = pend_byte_q;
    if (pend_q && fill_if.ready)
    begin
      pend_d = 1'b0;
    end
    if (rx_pulse)
    begin
      pend_d = 1'b1;
      pend_byte_d = rx_byte;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pend_q <= 1'b0;
      pend_byte_q <= sehp_pkg::BYTE_RST;
    end
    else
    begin
      pend_q <= pend_d;
      pend_byte_q <= pend_byte_d;
    end
  end

  sehp_fifo2 #(
    .WIDTH(sehp_pkg::BYTE_W),
    .DEPTH(sehp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr(fill_if),
    .o_rd(drain_if)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence engine, array and write timer.

  logic [7:0] mem_q [DEPTH];
  sehp_pkg::sehp_state_e st_q;
  sehp_pkg::sehp_state_e st_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic is_rd_q;
  logic is_rd_d;
  logic par_q;
  logic par_d;
  logic fpar_q;
  logic fpar_d;
  logic wpend_q;
  logic wpend_d;
  logic busy_q;
  logic busy_d;
  logic [CNT_W-1:0] wcnt_q;
  logic [CNT_W-1:0] wcnt_d;
  logic oe_q;
  logic oe_d;
  logic mem_we;
  logic take;
  logic frame_end;

  assign drain_if.ready = (st_q != sehp_pkg::ST_FETCH);
  assign take = drain_if.valid & drain_if.ready;
  // The frame closes only once every byte of it has been handled.
  assign frame_end = cs_s2_q & ~pend_q & ~drain_if.valid;

  always_comb
  begin
    st_d = st_q;
    addr_d = addr_q;
    hi_d = hi_q;
    is_rd_d = is_rd_q;
    par_d = take ? ~par_q : par_q;
    fpar_d = fpar_q;
    wpend_d = wpend_q;
    tx_even_d = tx_even_q;
    tx_odd_d = tx_odd_q;
    mem_we = 1'b0;
    busy_d = busy_q;
    wcnt_d = wcnt_q;
    if (busy_q)
    begin
      if (wcnt_q == '0)
      begin
        busy_d = 1'b0;
      end
      else
      begin
        wcnt_d = CNT_W'(wcnt_q - 1'b1);
      end
    end
    if (frame_end)
    begin
      st_d = sehp_pkg::ST_CMD;
      par_d = 1'b0;
      wpend_d = 1'b0;
      if (wpend_q)
      begin
        busy_d = 1'b1;
        wcnt_d = CNT_W'(WRITE_CYCLES - 1);
      end
    end
    else
    begin
      case (st_q)
        sehp_pkg::ST_CMD:
        begin
          if (take)
          begin
            if (busy_q)
            begin
              st_d = sehp_pkg::ST_DROP;
            end
            else if (drain_if.data == sehp_pkg::CMD_READ)
            begin
              is_rd_d = 1'b1;
              st_d = sehp_pkg::ST_ADDR_HI;
            end
            else if (drain_if.data == sehp_pkg::CMD_WRITE)
            begin
              is_rd_d = 1'b0;
              st_d = sehp_pkg::ST_ADDR_HI;
            end
            else
            begin
              st_d = sehp_pkg::ST_DROP;
            end
          end
        end
        sehp_pkg::ST_ADDR_HI:
        begin
          if (take)
          begin
            hi_d = drain_if.data;
            st_d = sehp_pkg::ST_ADDR_LO;
          end
        end
        sehp_pkg::ST_ADDR_LO:
        begin
          if (take)
          begin
            addr_d = addr_dec({hi_q, drain_if.data});
            fpar_d = par_q;
            st_d = is_rd_q ? sehp_pkg::ST_FETCH : sehp_pkg::ST_WDATA;
          end
        end
        sehp_pkg::ST_FETCH:
        begin
          // Fills the register that goes out two bytes after the one just received.
          if (fpar_q)
          begin
            tx_odd_d = mem_q[addr_q];
          end
          else
          begin
            tx_even_d = mem_q[addr_q];
          end
          addr_d = addr_inc(addr_q);
          st_d = sehp_pkg::ST_READ;
        end
        sehp_pkg::ST_READ:
        begin
          if (take)
          begin
            fpar_d = par_q;
            st_d = sehp_pkg::ST_FETCH;
          end
        end
        sehp_pkg::ST_WDATA:
        begin
          if (take)
          begin
            mem_we = 1'b1;
            addr_d = addr_inc(addr_q);
            wpend_d = 1'b1;
          end
        end
        sehp_pkg::ST_DROP:
        begin
          st_d = sehp_pkg::ST_DROP;
        end
        default:
        begin
          st_d = sehp_pkg::ST_CMD;
        end
      endcase
    end
    oe_d = ~cs_s2_q & hold_s2_q & (st_q == sehp_pkg::ST_FETCH || st_q == sehp_pkg::ST_READ);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= sehp_pkg::ST_CMD;
      addr_q <= '0;
      hi_q <= sehp_pkg::BYTE_RST;
      is_rd_q <= 1'b0;
      par_q <= 1'b0;
      fpar_q <= 1'b0;
      wpend_q <= 1'b0;
      tx_even_q <= sehp_pkg::BYTE_RST;
      tx_odd_q <= sehp_pkg::BYTE_RST;
      busy_q <= 1'b0;
      wcnt_q <= '0;
      oe_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      addr_q <= addr_d;
      hi_q <= hi_d;
      is_rd_q <= is_rd_d;
      par_q <= par_d;
      fpar_q <= fpar_d;
      wpend_q <= wpend_d;
      tx_even_q <= tx_even_d;
      tx_odd_q <= tx_odd_d;
      busy_q <= busy_d;
      wcnt_q <= wcnt_d;
      oe_q <= oe_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (mem_we)
    begin
      mem_q[addr_q] <= drain_if.data;
    end
  end

  assign o_so_oe = oe_q;
  assign o_busy = busy_q;
endmodule : sehp_eeprom_port

`default_nettype wire

// >>> verif/sehp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sehp_monitor #(
  parameter int DEPTH = 8192,
  parameter int WRITE_CYCLES = 50
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_hold_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_busy
);
  int bcnt_q;
  int bcnt_d;

  // Counts the cycles of the current busy run.
  always_comb bcnt_d = o_busy ? bcnt_q + 1 : 0;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      bcnt_q <= 0;
    else
      bcnt_q <= bcnt_d;
  end

  a_so_desel_low: assert property (@(posedge i_clk) disable iff (i_rst)
    i_cs_n |-> !o_so) else $error("so active while deselected");
  a_oe_desel_off: assert property (@(posedge i_clk) disable iff (i_rst)
    i_cs_n [*5] |-> !o_so_oe) else $error("so enabled while deselected");
  a_oe_hold_off: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_hold_n && !i_cs_n) [*5] |-> !o_so_oe) else $error("so enabled while paused");
  a_so_high_stable: assert property (@(posedge i_clk) disable iff (i_rst)
    i_sck && $past(i_sck) && !i_cs_n |-> $stable(o_so)) else $error("so moved while sck high");
  a_so_hold_frozen: assert property (@(posedge i_sck) disable iff (i_rst)
    !i_hold_n && $past(!i_hold_n) && !i_cs_n && $past(!i_cs_n) |-> $stable(o_so))
    else $error("so shifted while paused");
  a_busy_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    o_busy |-> bcnt_q < WRITE_CYCLES + 2) else $error("write cycle too long");
  a_busy_full: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_busy) |-> bcnt_q >= WRITE_CYCLES) else $error("write cycle too short");
  a_busy_after_desel: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2)) else $error("busy without deselect");
endmodule : sehp_monitor
`default_nettype wire

// >>> verif/sehp_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module sehp_spi_master (
  input wire logic i_so,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_hold_n,
  output logic o_si
);
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_hold_n = 1'b1;
    o_si = 1'b0;
  end

  // Mode 0, MSB first.
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      o_si = tx[i];
      #15 o_sck = 1'b1;
      rx[i] = i_so;
      #15 o_sck = 1'b0;
    end
  endtask : xbyte

  task automatic spin(input int n);
    repeat (n)
    begin
      o_si = ~o_si;
      #15 o_sck = 1'b1;
      #15 o_sck = 1'b0;
    end
  endtask : spin

  // Called only between bits, so the serial clock is low here; the wait keeps it clear of the falling edge.
  task automatic hold(input logic v);
    #20 o_hold_n = v;
    #40;
  endtask : hold

  // Around a frame edge the data line shows the inverse of its last bit.
  task automatic sel(input logic v);
    #20 o_si = ~o_si;
    #20 o_cs_n = v;
    #40;
  endtask : sel
endmodule : sehp_spi_master
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DEP = 1024;
  localparam int WC = 50;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  wire logic sck;
  wire logic cs_n;
  wire logic hold_n;
  wire logic si;
  wire logic o_so;
  wire logic o_so_oe;
  wire logic o_busy;
  wire logic so_w = o_so_oe ? o_so : 1'bz;
  int err_total = 0;
  int checks = 0;
  logic [15:0] lf = 16'hD154;
  logic [15:0] a;
  logic [7:0] mem [int];

  always #2 i_clk = ~i_clk;

  sehp_eeprom_port #(.DEPTH(DEP), .WRITE_CYCLES(WC)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_hold_n(hold_n),
    .i_si(si), .o_so(o_so), .o_so_oe(o_so_oe), .o_busy(o_busy)
  );
  sehp_spi_master m (.i_so(so_w), .o_sck(sck), .o_cs_n(cs_n), .o_hold_n(hold_n), .o_si(si));

  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic pz();
    m.hold(1'b0);
    m.spin(3);
    chk(o_so_oe, 1'b0);
    m.hold(1'b1);
  endtask : pz

  task automatic wr(input logic [15:0] ad, input int n, input bit p);
    logic [7:0] r;
    logic [7:0] d;
    int k;
    m.sel(1'b0);
    m.xbyte(8'h02, r);
    m.xbyte(ad[15:8], r);
    if (p)
      pz();
    m.xbyte(ad[7:0], r);
    for (int i = 0; i < n; i++)
    begin
      d = rnd();
      mem[(ad + i) % DEP] = d;
      m.xbyte(d, r);
    end
    m.sel(1'b1);
    chk(o_busy, 1'b1);
    k = 0;
    while (o_busy === 1'b1 && k < 2 * WC)
    begin
      @(posedge i_clk);
      k++;
    end
    // Busy starts a few cycles after deselect and the wait begins ten cycles after it.
    chk(k < WC, 1'b1);
    chk(k > WC - 12, 1'b1);
  endtask : wr

  task automatic rd(input logic [15:0] ad, input int n, input int p);
    logic [7:0] r;
    m.sel(1'b0);
    m.xbyte(8'h03, r);
    m.xbyte(ad[15:8], r);
    if (p == 1)
      pz();
    m.xbyte(ad[7:0], r);
    m.xbyte(rnd(), r);
    for (int i = 0; i < n; i++)
    begin
      if (p == 2 && i == 1)
        pz();
      m.xbyte(rnd(), r);
      chk(r, mem[(ad + i) % DEP]);
    end
    m.sel(1'b1);
    chk(o_so_oe, 1'b0);
  endtask : rd

  initial
  begin
    repeat (8) @(posedge i_clk);
    #1 i_rst = 1'b0;
    repeat (8) @(posedge i_clk);
    // An odd byte count in the next frame must not push a stray byte over the word at 2.
    #1 wr(16'h0402, 3, 1'b0);
    wr(16'hFFFE, 4, 1'b0);
    rd(16'h03FE, 5, 2);
    m.spin(8);
    chk(o_so_oe, 1'b0);
    @(posedge i_clk);
    #1 i_rst = 1'b1;
    repeat (8) @(posedge i_clk);
    #1 i_rst = 1'b0;
    @(posedge i_clk);
    #1 chk(o_busy, 1'b0);
    chk(o_so_oe, 1'b0);
    repeat (8) @(posedge i_clk);
    #1 rd(16'h0000, 2, 1);
    repeat (3)
    begin
      a = {rnd(), rnd()};
      wr(a, 3, 1'b1);
      rd(a, 3, 2);
    end
    summarize();
  end

  initial
  begin
    #100000;
    err_total++;
    summarize();
  end
endmodule : tb_top

bind sehp_eeprom_port sehp_monitor #(.DEPTH(DEPTH), .WRITE_CYCLES(WRITE_CYCLES)) u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n),
  .i_hold_n(i_hold_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_busy(o_busy)
);
`default_nettype wire
